//--- design/ireqen_pkg.sv
package ireqen_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_REQ0 = 12'hfc0;
   localparam logic [11:0] OFS_ENH0 = 12'hfc1;
   localparam logic [11:0] OFS_ENL0 = 12'hfc2;
   localparam logic [11:0] OFS_REQ1 = 12'hfc3;
   localparam logic [11:0] OFS_REQ2 = 12'hfc6;
   localparam logic [11:0] OFS_EVT_STATUS = 12'hfc9;
   localparam logic [11:0] OFS_EVT_CLEAR = 12'hfca;
   localparam logic [11:0] OFS_EVT_ENABLE = 12'hfcb;
   localparam logic [11:0] OFS_CONTROL = 12'hfcf;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int GE_BIT = 7;
   // ------------------------------------------------------------
   // sources and levels
   // ------------------------------------------------------------
   localparam int NUM_BANKS = 3;
   localparam int NUM_SRC = 24;
   localparam int IDX_W = 5;
   // pulse-type sources per bank, the rest are level-held
   localparam logic [7:0] PULSE_BANK0 = 8'he1;
   localparam logic [7:0] PULSE_BANK1 = 8'hff;
   localparam logic [7:0] PULSE_BANK2 = 8'h9f;
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [1:0] LVL_ONE = 2'h1;
   localparam logic [1:0] LVL_TOP = 2'h3;
   // event status bits
   localparam int EVT_ACK = 0;
   localparam int EVT_OVERRUN = 1;
   localparam int EVT_POLLED = 2;
   localparam int EVT_W = 3;
endpackage : ireqen_pkg

//--- design/ireqen_arb_if.sv
`timescale 1ns/1ps
// pending requests with their levels, and the winner
interface ireqen_arb_if;
   logic [23:0] req;
   logic [23:0][1:0] level;
   logic grantValid;
   logic [4:0] grantIdx;
   logic [1:0] grantLevel;
   modport arb (input req, input level, output grantValid, output grantIdx, output grantLevel);
   modport ctl (output req, output level, input grantValid, input grantIdx, input grantLevel);
endinterface : ireqen_arb_if

//--- design/ireqen_flag_bank.sv
`timescale 1ns/1ps
module ireqen_flag_bank #(
   parameter logic [7:0] PULSE_MASK = 8'h00
) (
   // clock and reset
   input wire logic coreClk,
   input wire logic reset,
   // sources and clears
   input wire logic [7:0] srcReq,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic [7:0] ackClr,
   // pending flags
   output logic [7:0] flags_r
);
   logic [7:0] flags_nxt;

   // ------------------------------------------------------------
   // pending flag latch
   // ------------------------------------------------------------
   // write first, then ack, then new requests on top so none is lost
   always_comb begin
      flags_nxt = flags_r;
      if (wrEn) begin
         flags_nxt = wrData; // zero write clears, held source resets it
      end
      flags_nxt = flags_nxt & ~(ackClr & PULSE_MASK); // ack clears pulse sources only
      flags_nxt = flags_nxt | srcReq; // set wins over clear
   end

   always_ff @(posedge coreClk) begin
      if (reset) begin
         flags_r <= ireqen_pkg::RST_BYTE;
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule : ireqen_flag_bank

//--- design/ireqen_arbiter.sv
`timescale 1ns/1ps
module ireqen_arbiter (
   // requests in, winner out
   ireqen_arb_if.arb arbBus
);
   // ------------------------------------------------------------
   // level then vector order
   // ------------------------------------------------------------
   // scan from the top level down; lower index is earlier in vector order
   always_comb begin
      logic found;
      found = 1'b0;
      arbBus.grantValid = 1'b0;
      arbBus.grantIdx = '0;
      arbBus.grantLevel = ireqen_pkg::LVL_OFF;
      for (int l = int'(ireqen_pkg::LVL_TOP); l >= int'(ireqen_pkg::LVL_ONE); l--) begin
         for (int k = 0; k < ireqen_pkg::NUM_SRC; k++) begin
            if (!found && arbBus.req[k] && arbBus.level[k] == l[1:0]) begin
               found = 1'b1;
               arbBus.grantValid = 1'b1;
               arbBus.grantIdx = k[4:0];
               arbBus.grantLevel = l[1:0];
            end
         end
      end
   end
endmodule : ireqen_arbiter

//--- design/ireqen_top.sv
`timescale 1ns/1ps
module ireqen_top (
   // clock and reset
   input wire logic coreClk,
   input wire logic reset,
   // register port
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [7:0] regRdData_r,
   // bank0 sources: timer2..timer0, uart0 rx/tx, two-wire, spi, converter
   input wire logic [7:0] srcBank0,
   // port a and port d pin events with selection
   input wire logic [7:0] portAEvent,
   input wire logic [7:0] portDEvent,
   input wire logic [7:0] portSelect,
   // bank2 sources: timer3, uart1 rx/tx, transfer engine, port c pins 3..0
   input wire logic [7:0] srcBank2,
   // enables of banks 1 and 2 held elsewhere
   input wire logic [7:0] enableHighBank1,
   input wire logic [7:0] enableLowBank1,
   input wire logic [7:0] enableHighBank2,
   input wire logic [7:0] enableLowBank2,
   // processor core
   input wire logic coreAck,
   input wire logic coreEnableInt,
   input wire logic coreDisableInt,
   output logic coreIrq_r,
   output logic [4:0] coreVector_r,
   output logic globalEnable_r,
   // event interrupt
   output logic eventIrq_r
);
   logic [7:0] flagBank [3];
   logic [7:0] srcBank [3];
   logic [7:0] wrBank [3];
   logic [7:0] ackBank [3];
   logic [23:0] ackVec;
   logic [7:0] enableHigh0_r, enableHigh0_nxt;
   logic [7:0] enableLow0_r, enableLow0_nxt;
   logic [2:0] evtStatus_r, evtStatus_nxt;
   logic [2:0] evtEnable_r, evtEnable_nxt;
   logic globalEnable_nxt;
   logic [7:0] regRdData_nxt;
   logic coreIrq_nxt;
   logic [4:0] coreVector_nxt;
   logic eventIrq_nxt;
   logic ackTaken;
   logic [2:0] evtSet;
   logic [7:0] enHigh [3];
   logic [7:0] enLow [3];
   localparam logic [2:0][7:0] PULSE_MASKS = {ireqen_pkg::PULSE_BANK2, ireqen_pkg::PULSE_BANK1,
                                               ireqen_pkg::PULSE_BANK0};
   ireqen_arb_if arbBus ();

   // one-hot decode of a vector index, used for the ack clear
   function automatic logic [23:0] idxOneHot(input logic [4:0] idx);
      logic [23:0] v;
      v = '0;
      for (int k = 0; k < ireqen_pkg::NUM_SRC; k++) begin
         if (idx == k[4:0]) begin
            v[k] = 1'b1;
         end
      end
      return v;
   endfunction : idxOneHot

   // register address match
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction : hit

   // ------------------------------------------------------------
   // source routing
   // ------------------------------------------------------------
   // only the selected port drives each pin flag
   assign srcBank[0] = srcBank0;
   assign srcBank[1] = (portAEvent & ~portSelect) | (portDEvent & portSelect);
   assign srcBank[2] = srcBank2;
   assign wrBank[0] = {8{regWrStrobe && hit(regAddr, ireqen_pkg::OFS_REQ0)}};
   assign wrBank[1] = {8{regWrStrobe && hit(regAddr, ireqen_pkg::OFS_REQ1)}};
   assign wrBank[2] = {8{regWrStrobe && hit(regAddr, ireqen_pkg::OFS_REQ2)}};
   assign enHigh[0] = enableHigh0_r;
   assign enLow[0] = enableLow0_r;
   assign enHigh[1] = enableHighBank1;
   assign enLow[1] = enableLowBank1;
   assign enHigh[2] = enableHighBank2;
   assign enLow[2] = enableLowBank2;
   // ack only counts while a request is being offered
   assign ackTaken = coreAck && coreIrq_r;
   assign ackVec = ackTaken ? idxOneHot(coreVector_r) : '0;

   // ------------------------------------------------------------
   // flag banks and vector-order flattening
   // ------------------------------------------------------------
   // vector order: bank0 bit7 first, bank2 bit0 last
   for (genvar b = 0; b < ireqen_pkg::NUM_BANKS; b++) begin : gBank
      for (genvar i = 0; i < 8; i++) begin : gBit
         assign arbBus.req[b * 8 + i] = flagBank[b][7 - i];
         assign arbBus.level[b * 8 + i] = {enHigh[b][7 - i], enLow[b][7 - i]};
         assign ackBank[b][7 - i] = ackVec[b * 8 + i];
      end
      ireqen_flag_bank #(
         .PULSE_MASK(PULSE_MASKS[b])
      ) uFlags (
         .coreClk(coreClk),
         .reset(reset),
         .srcReq(srcBank[b]),
         .wrEn(wrBank[b][0]),
         .wrData(regWrData),
         .ackClr(ackBank[b]),
         .flags_r(flagBank[b])
      );
   end

   ireqen_arbiter uArb (
      .arbBus(arbBus.arb)
   );

   // ------------------------------------------------------------
   // register writes, global enable, events
   // ------------------------------------------------------------
   always_comb begin
      enableHigh0_nxt = enableHigh0_r;
      enableLow0_nxt = enableLow0_r;
      evtEnable_nxt = evtEnable_r;
      globalEnable_nxt = globalEnable_r;
      if (regWrStrobe && hit(regAddr, ireqen_pkg::OFS_ENH0)) begin
         enableHigh0_nxt = regWrData;
      end
      if (regWrStrobe && hit(regAddr, ireqen_pkg::OFS_ENL0)) begin
         enableLow0_nxt = regWrData;
      end
      if (regWrStrobe && hit(regAddr, ireqen_pkg::OFS_EVT_ENABLE)) begin
         evtEnable_nxt = regWrData[2:0];
      end
      if (regWrStrobe && hit(regAddr, ireqen_pkg::OFS_CONTROL)) begin
         globalEnable_nxt = regWrData[ireqen_pkg::GE_BIT];
      end
      if (coreEnableInt) begin
         globalEnable_nxt = 1'b1;
      end
      // disable and ack override any enable in the same cycle
      if (coreDisableInt || ackTaken) begin
         globalEnable_nxt = 1'b0;
      end
      evtSet = '0;
      evtSet[ireqen_pkg::EVT_ACK] = ackTaken;
      evtSet[ireqen_pkg::EVT_OVERRUN] = |((srcBank[0] & flagBank[0]) | (srcBank[1] & flagBank[1])
                                         | (srcBank[2] & flagBank[2]));
      evtSet[ireqen_pkg::EVT_POLLED] = !globalEnable_r && |(srcBank[0] | srcBank[1] | srcBank[2]);
      evtStatus_nxt = evtStatus_r;
      if (regWrStrobe && hit(regAddr, ireqen_pkg::OFS_EVT_CLEAR)) begin
         evtStatus_nxt = evtStatus_r & ~regWrData[2:0];
      end
      evtStatus_nxt = evtStatus_nxt | evtSet; // set beats clear
      eventIrq_nxt = |(evtStatus_nxt & evtEnable_nxt);
   end

   // ------------------------------------------------------------
   // core request and read data
   // ------------------------------------------------------------
   // request drops right after an ack because the enable goes low with it
   always_comb begin
      coreIrq_nxt = arbBus.grantValid && globalEnable_nxt;
      coreVector_nxt = arbBus.grantIdx;
      regRdData_nxt = ireqen_pkg::RST_BYTE;
      if (regRdStrobe) begin
         case (regAddr)
            ireqen_pkg::OFS_REQ0: regRdData_nxt = flagBank[0];
            ireqen_pkg::OFS_ENH0: regRdData_nxt = enableHigh0_r;
            ireqen_pkg::OFS_ENL0: regRdData_nxt = enableLow0_r;
            ireqen_pkg::OFS_REQ1: regRdData_nxt = flagBank[1];
            ireqen_pkg::OFS_REQ2: regRdData_nxt = flagBank[2];
            ireqen_pkg::OFS_EVT_STATUS: regRdData_nxt = {5'h00, evtStatus_r};
            ireqen_pkg::OFS_EVT_ENABLE: regRdData_nxt = {5'h00, evtEnable_r};
            ireqen_pkg::OFS_CONTROL: regRdData_nxt = {globalEnable_r, 7'h00};
            default: regRdData_nxt = ireqen_pkg::RST_BYTE; // unmapped and clear register read zero
         endcase
      end
   end

   always_ff @(posedge coreClk) begin
      if (reset) begin
         enableHigh0_r <= ireqen_pkg::RST_BYTE;
         enableLow0_r <= ireqen_pkg::RST_BYTE;
         evtEnable_r <= '0;
         evtStatus_r <= '0;
         globalEnable_r <= 1'b0;
         eventIrq_r <= 1'b0;
         coreIrq_r <= 1'b0;
         coreVector_r <= '0;
         regRdData_r <= ireqen_pkg::RST_BYTE;
      end else begin
         enableHigh0_r <= enableHigh0_nxt;
         enableLow0_r <= enableLow0_nxt;
         evtEnable_r <= evtEnable_nxt;
         evtStatus_r <= evtStatus_nxt;
         globalEnable_r <= globalEnable_nxt;
         eventIrq_r <= eventIrq_nxt;
         coreIrq_r <= coreIrq_nxt;
         coreVector_r <= coreVector_nxt;
         regRdData_r <= regRdData_nxt;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge coreClk); endclocking
   default disable iff (reset);

   // highest pending enabled level, independent of the arbiter loop
   logic [1:0] maxLevel;
   always_comb begin
      maxLevel = ireqen_pkg::LVL_OFF;
      for (int k = 0; k < ireqen_pkg::NUM_SRC; k++) begin
         if (arbBus.req[k] && arbBus.level[k] > maxLevel) begin
            maxLevel = arbBus.level[k];
         end
      end
   end

   request_latch_a: assert property (srcBank0 != 8'h00 |=> (flagBank[0] & $past(srcBank0)) == $past(srcBank0))
      else $error("bank0 request not latched");
   forward_enable_a: assert property ($rose(coreIrq_r) |-> $past(arbBus.grantValid) && globalEnable_r)
      else $error("request forwarded while globally disabled");
   polled_quiet_a: assert property (!globalEnable_r && !coreEnableInt && !regWrStrobe |=> !coreIrq_r)
      else $error("core request while polling");
   read_bank0_a: assert property (regRdStrobe && regAddr == ireqen_pkg::OFS_REQ0 |=> regRdData_r == $past(flagBank[0]))
      else $error("bank0 read mismatch");
   port_select_a: assert property (!$past(wrBank[1][0]) |-> ((flagBank[1] & ~$past(flagBank[1])) & ~$past(srcBank[1])) == 8'h00)
      else $error("pin flag set by unselected port");
   level_first_a: assert property (arbBus.grantValid |-> arbBus.grantLevel == maxLevel && maxLevel != ireqen_pkg::LVL_OFF)
      else $error("lower level granted");
   ack_pulse_a: assert property (ackTaken && coreVector_r == 5'h00 && !regWrStrobe && !srcBank0[7] |=> !flagBank[0][7])
      else $error("pulse flag kept after ack");
   ack_held_a: assert property (ackTaken && coreVector_r == 5'h03 && flagBank[0][4] && !regWrStrobe |=> flagBank[0][4])
      else $error("held flag cleared by ack");
   ack_disable_a: assert property (ackTaken |=> !globalEnable_r ##1 !coreIrq_r)
      else $error("global enable not cleared by ack");
endmodule : ireqen_top

//--- verif/ireqen_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// processor core: takes a request, then returns from the handler
// ---------------------------------------------------------------
module ireqen_core_model (
   // clock and reset
   input wire logic coreClk,
   input wire logic reset,
   // request side and behaviour knobs
   input wire logic coreIrq,
   input wire logic [3:0] ackDelay,
   input wire logic retOn,
   // answers to the block
   output logic coreAck,
   output logic coreReturn
);
   logic [3:0] waitCnt;
   logic [1:0] retCnt;
   // one ack per request; the return comes only after a short handler
   always @(posedge coreClk) begin
      coreAck <= 1'b0;
      coreReturn <= 1'b0;
      if (reset) begin
         waitCnt <= 4'h0;
         retCnt <= 2'h0;
      end else if (retCnt != 2'h0) begin
         retCnt <= retCnt - 2'h1;
         coreReturn <= (retCnt == 2'h1) && retOn;
      end else if (coreIrq && !coreAck) begin
         if (waitCnt >= ackDelay) begin
            coreAck <= 1'b1;
            waitCnt <= 4'h0;
            retCnt <= 2'h3;
         end else begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule : ireqen_core_model

//--- verif/ireqen_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errTotal++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module ireqen_test;
   logic coreClk, reset, regWrStrobe, regRdStrobe, coreAck, coreReturn, coreDisableInt, retOn;
   logic coreIrq_r, globalEnable_r, eventIrq_r, rdPrev, ackPrev;
   logic [11:0] regAddr;
   logic [7:0] regWrData, regRdData_r, srcBank0, srcBank2, portAEvent, portDEvent, portSelect, zeroEn;
   logic [4:0] coreVector_r;
   logic [3:0] ackDelay;
   logic [31:0] seed;
   logic [11:0] regMap [5];
   logic [7:0] rdQ [$];
   logic [4:0] vecQ [$];
   int errTotal, checked, cycles;
   // ---------------------------------------------------------------
   // block, core model and clock
   // ---------------------------------------------------------------
   ireqen_top ireqen_top_i (.coreClk(coreClk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData_r(regRdData_r), .srcBank0(srcBank0),
      .portAEvent(portAEvent), .portDEvent(portDEvent), .portSelect(portSelect), .srcBank2(srcBank2),
      .enableHighBank1(zeroEn), .enableLowBank1(zeroEn), .enableHighBank2(zeroEn), .enableLowBank2(zeroEn),
      .coreAck(coreAck), .coreEnableInt(coreReturn), .coreDisableInt(coreDisableInt), .coreIrq_r(coreIrq_r),
      .coreVector_r(coreVector_r), .globalEnable_r(globalEnable_r), .eventIrq_r(eventIrq_r));
   ireqen_core_model ireqen_core_model_i (.coreClk(coreClk), .reset(reset), .coreIrq(coreIrq_r),
      .ackDelay(ackDelay), .retOn(retOn), .coreAck(coreAck), .coreReturn(coreReturn));
   initial begin
      coreClk = 1'b0;
      forever #50 coreClk = ~coreClk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   // bus cycles: a gap edge after each so a strobe is never re-driven in one step
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge coreClk);
      regWrStrobe <= 1'b0;
      @(posedge coreClk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      rdQ.push_back(e);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge coreClk);
      regRdStrobe <= 1'b0;
      @(posedge coreClk);
   endtask : rd
   task automatic src(input logic [7:0] b0, input logic [7:0] b2, input logic [7:0] pa, input logic [7:0] pd);
      srcBank0 <= b0;
      srcBank2 <= b2;
      portAEvent <= pa;
      portDEvent <= pd;
      @(posedge coreClk);
      {srcBank0, srcBank2, portAEvent, portDEvent} <= 32'h0;
      @(posedge coreClk);
   endtask : src
   task automatic settle;
      for (int w = 0; w < 300 && !(vecQ.size() == 0 && coreIrq_r === 1'b0 && !coreAck); w++) begin
         @(posedge coreClk);
      end
      `CHK(vecQ.size() == 0, 1'b1)
   endtask : settle
   // monitor: read data one cycle after the strobe, vector at each ack
   always @(posedge coreClk) begin
      cycles++;
      if (rdPrev && rdQ.size() > 0) `CHK(regRdData_r, rdQ.pop_front())
      if (ackPrev) `CHK({globalEnable_r, coreIrq_r}, 2'b00)
      if (coreAck && coreIrq_r === 1'b1 && vecQ.size() > 0) `CHK(coreVector_r, vecQ.pop_front())
      else if (coreAck && coreIrq_r === 1'b1) `CHK(5'h1f, 5'h00)
      rdPrev = regRdStrobe;
      ackPrev = coreAck && coreIrq_r;
      if (cycles == 20000) begin
         errTotal++;
         complete_run();
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {reset, regWrStrobe, regRdStrobe, coreDisableInt, retOn, rdPrev, ackPrev} = 7'b1000100;
      {regAddr, regWrData, srcBank0, srcBank2, portAEvent, portDEvent, portSelect, zeroEn} = 68'h0;
      ackDelay = 4'h0;
      seed = 32'h9bb63e92;
      regMap = '{ireqen_pkg::OFS_REQ0, ireqen_pkg::OFS_ENH0, ireqen_pkg::OFS_ENL0, ireqen_pkg::OFS_REQ1,
         ireqen_pkg::OFS_REQ2};
      repeat (10) @(posedge coreClk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(regMap[i], 8'h00);
         seed = lfsr(seed);
         wr(regMap[i], seed[7:0]);
         rd(regMap[i], seed[7:0]);
         wr(regMap[i], 8'h00);
         rd(regMap[i], 8'h00);
      end
      wr(12'h123, 8'hff);
      rd(12'h123, 8'h00);
      $display("registers done");
      for (int b = 0; b < 8; b++) begin
         src(8'h01 << b, 8'h00, 8'h00, 8'h00);
         rd(ireqen_pkg::OFS_REQ0, 8'h01 << b);
         wr(ireqen_pkg::OFS_REQ0, 8'h00);
      end
      seed = lfsr(seed);
      portSelect <= seed[7:0];
      src(8'h00, 8'h00, 8'hff, 8'h00);
      rd(ireqen_pkg::OFS_REQ1, ~seed[7:0]);
      wr(ireqen_pkg::OFS_REQ1, 8'h00);
      src(8'h00, 8'h00, 8'h00, 8'hff);
      rd(ireqen_pkg::OFS_REQ1, seed[7:0]);
      src(8'h00, 8'hff, 8'h00, 8'h00);
      rd(ireqen_pkg::OFS_REQ2, 8'hff);
      wr(ireqen_pkg::OFS_REQ2, 8'h00);
      $display("mapping done");
      // timer2 at level 1 against the converter at each level code; core fast then slow
      for (int c = 0; c < 4; c++) begin
         ackDelay <= 4'(c * 3);
         wr(ireqen_pkg::OFS_ENH0, {7'h00, c[1]});
         wr(ireqen_pkg::OFS_ENL0, {1'b1, 6'h00, c[0]});
         if (c >= 2) vecQ.push_back(5'h07);
         vecQ.push_back(5'h00);
         if (c == 1) vecQ.push_back(5'h07);
         wr(ireqen_pkg::OFS_REQ0, 8'h81);
         rd(ireqen_pkg::OFS_REQ0, 8'h81);
         `CHK(coreIrq_r, 1'b0)
         wr(ireqen_pkg::OFS_CONTROL, 8'h80);
         settle();
         rd(ireqen_pkg::OFS_REQ0, (c == 0) ? 8'h01 : 8'h00);
         coreDisableInt <= 1'b1;
         @(posedge coreClk);
         coreDisableInt <= 1'b0;
         wr(ireqen_pkg::OFS_REQ0, 8'h00);
      end
      $display("priority done");
      retOn <= 1'b0;
      wr(ireqen_pkg::OFS_ENH0, 8'h10);
      wr(ireqen_pkg::OFS_ENL0, 8'h10);
      srcBank0 <= 8'h10;
      vecQ.push_back(5'h03);
      wr(ireqen_pkg::OFS_CONTROL, 8'h80);
      settle();
      rd(ireqen_pkg::OFS_REQ0, 8'h10);
      wr(ireqen_pkg::OFS_REQ0, 8'h00);
      rd(ireqen_pkg::OFS_REQ0, 8'h10);
      srcBank0 <= 8'h00;
      wr(ireqen_pkg::OFS_REQ0, 8'h00);
      rd(ireqen_pkg::OFS_REQ0, 8'h00);
      $display("held source done");
      wr(ireqen_pkg::OFS_EVT_CLEAR, 8'h07);
      rd(ireqen_pkg::OFS_EVT_STATUS, 8'h00);
      src(8'h00, 8'h80, 8'h00, 8'h00);
      src(8'h00, 8'h80, 8'h00, 8'h00);
      rd(ireqen_pkg::OFS_EVT_STATUS, 8'h06);
      `CHK(eventIrq_r, 1'b0)
      wr(ireqen_pkg::OFS_EVT_ENABLE, 8'h04);
      @(posedge coreClk);
      `CHK(eventIrq_r, 1'b1)
      wr(ireqen_pkg::OFS_EVT_CLEAR, 8'h04);
      @(posedge coreClk);
      `CHK(eventIrq_r, 1'b0)
      rd(ireqen_pkg::OFS_EVT_STATUS, 8'h02);
      rd(ireqen_pkg::OFS_EVT_CLEAR, 8'h00);
      $display("events done");
      complete_run();
   end
endmodule : ireqen_test
